/* pc_cycler.sv */
// preset cycling sequencer with two selectable output lines
`timescale 1ns/1ps
module pc_cycler
   import pc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic output_line_picker_i,
   input wire logic line_cfg_we_i,
   input wire logic [1:0] output_source_choice_i,
   input wire logic sw_latch_ctrl_i,
   input wire logic output_level_value_i,
   input wire logic sw_latch_apply_i,
   input wire logic exposure_begin_event_i,
   input wire logic exposure_window_level_i,
   input wire logic preset_cycle_enable_i,
   input wire logic [IDX_W-1:0] preset_total_i,
   input wire logic [1:0] advance_event_choice_i,
   input wire logic [DIV_W-1:0] advance_divider_i,
   input wire logic [1:0] rewind_event_choice_i,
   input wire logic frame_begin_event_i,
   input wire logic accepted_trigger_event_i,
   input wire logic counter_done_event_i,
   input wire logic sw_advance_i,
   input wire logic acquisition_end_event_i,
   input wire logic sw_rewind_i,
   input wire logic feature_pick_i,
   input wire logic feature_join_i,
   input wire logic feature_join_we_i,
   input wire logic [IDX_W-1:0] preset_edit_index_i,
   input wire logic preset_wr_i,
   input wire logic [DIV_W-1:0] per_preset_divider_i,
   input wire logic [POS_W-1:0] roi_x_origin_i,
   input wire logic [POS_W-1:0] roi_y_origin_i,
   input wire logic [POS_W-1:0] base_roi_x_i,
   input wire logic [POS_W-1:0] base_roi_y_i,
   output logic [IDX_W-1:0] active_preset_o,
   output logic [POS_W-1:0] roi_x_o,
   output logic [POS_W-1:0] roi_y_o,
   output logic [NUM_FEAT-1:0] base_locked_o,
   output logic preset_wr_refused_o,
   output wire logic [NUM_LINES-1:0] line_closed_o,
   output wire logic [NUM_LINES-1:0] line_sourced_o
);

   // ******************************************
   // sequencer state
   // ******************************************
   logic [IDX_W-1:0] idx_ff;
   logic [DIV_W-1:0] cnt_ff;
   logic pend_ff;
   logic [NUM_FEAT-1:0] join_ff;
   logic adv_ev;
   logic rew_ev;
   logic sync_src;
   logic rew_now;
   logic [DIV_W-1:0] div_eff;
   logic [DIV_W-1:0] nxt_cnt;
   logic roll;
   logic [IDX_W-1:0] nxt_idx_wrap;

   pc_preset_if pif ();

   pc_preset_mem #(
      .DEPTH(2 ** IDX_W)
   ) u_mem (
      .clk_i(clk_i),
      .bus(pif)
   );

   // event selection and classification
   always_comb begin
      unique case (pc_adv_src_t'(advance_event_choice_i))
         PC_ADV_FRAME: adv_ev = frame_begin_event_i;
         PC_ADV_TRIG: adv_ev = accepted_trigger_event_i;
         PC_ADV_COUNTER: adv_ev = counter_done_event_i;
         PC_ADV_NONE: adv_ev = sw_advance_i;
      endcase
      unique case (pc_rew_src_t'(rewind_event_choice_i))
         PC_REW_NONE: rew_ev = 1'b0;
         PC_REW_ACQ_END: rew_ev = acquisition_end_event_i;
         PC_REW_SW: rew_ev = sw_rewind_i;
         PC_REW_BOTH: rew_ev = acquisition_end_event_i | sw_rewind_i;
      endcase
   end

   assign sync_src = (advance_event_choice_i == PC_ADV_FRAME) ||
                     (advance_event_choice_i == PC_ADV_TRIG);
   assign rew_now = rew_ev && !sync_src;

   // divider of the active preset, or the common one; zero acts as one
   assign div_eff = join_ff[FEAT_DIV] ? pif.rd_data.divider : advance_divider_i;
   assign nxt_cnt = cnt_ff + 16'h0001;
   assign roll = (nxt_cnt >= div_eff);
   assign nxt_idx_wrap = (idx_ff >= preset_total_i) ? FIRST_PRESET : idx_ff + 5'h01;

   // ******************************************
   // index, count and deferred rewind
   // ******************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         idx_ff <= FIRST_PRESET;
         cnt_ff <= CNT_ZERO;
         pend_ff <= 1'b0;
      end else if (!preset_cycle_enable_i) begin
         idx_ff <= FIRST_PRESET;
         cnt_ff <= CNT_ZERO;
         pend_ff <= 1'b0;
      end else if (rew_now) begin
         idx_ff <= FIRST_PRESET;
         cnt_ff <= CNT_ZERO;
         pend_ff <= 1'b0;
      end else if (adv_ev) begin
         if (pend_ff) begin
            idx_ff <= FIRST_PRESET;
            cnt_ff <= CNT_ZERO;
            pend_ff <= rew_ev; // a new request in the same cycle waits for the next advance
         end else if (roll) begin
            idx_ff <= nxt_idx_wrap;
            cnt_ff <= CNT_ZERO;
            pend_ff <= rew_ev;
         end else begin
            cnt_ff <= nxt_cnt;
            pend_ff <= rew_ev;
         end
      end else if (rew_ev) begin
         pend_ff <= 1'b1;
      end
   end

   // ******************************************
   // feature join flags and preset writes
   // ******************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         join_ff <= '0;
      end else if (feature_join_we_i) begin
         join_ff[feature_pick_i] <= feature_join_i;
      end
   end

   // the active preset is refused so the running sequence never sees a torn entry
   assign pif.wr_en = preset_wr_i && !(preset_cycle_enable_i && preset_edit_index_i == idx_ff);
   assign pif.wr_addr = preset_edit_index_i;
   assign pif.wr_data = '{divider: per_preset_divider_i, x_origin: roi_x_origin_i, y_origin: roi_y_origin_i};
   assign pif.rd_addr = idx_ff;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         preset_wr_refused_o <= 1'b0;
      end else begin
         preset_wr_refused_o <= preset_wr_i && !pif.wr_en;
      end
   end

   // ******************************************
   // active preset outputs
   // ******************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         active_preset_o <= FIRST_PRESET;
         roi_x_o <= '0;
         roi_y_o <= '0;
         base_locked_o <= '0;
      end else begin
         active_preset_o <= idx_ff;
         base_locked_o <= join_ff & {NUM_FEAT{preset_cycle_enable_i}};
         if (preset_cycle_enable_i && join_ff[FEAT_ROI]) begin
            roi_x_o <= pif.rd_data.x_origin;
            roi_y_o <= pif.rd_data.y_origin;
         end else begin
            roi_x_o <= base_roi_x_i;
            roi_y_o <= base_roi_y_i;
         end
      end
   end

   // ******************************************
   // output lines
   // ******************************************
   for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
      logic [1:0] src_ff;
      logic latch_ff;
      logic lvl_wr_ff;
      logic applied_ff;
      logic nxt_applied;
      logic [PCNT_W-1:0] pcnt_ff;
      logic closed_ff;
      logic sourced_ff;
      logic pick;

      assign pick = (output_line_picker_i == 1'(g));

      always_comb begin
         nxt_applied = applied_ff;
         if (line_cfg_we_i && pick && !sw_latch_ctrl_i) begin
            nxt_applied = output_level_value_i;
         end else if (sw_latch_apply_i && pick && latch_ff) begin
            nxt_applied = lvl_wr_ff;
         end
      end

      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            src_ff <= PC_SRC_OFF;
            latch_ff <= 1'b0;
            lvl_wr_ff <= 1'b0;
            applied_ff <= 1'b0;
         end else begin
            applied_ff <= nxt_applied;
            if (line_cfg_we_i && pick) begin
               src_ff <= output_source_choice_i;
               latch_ff <= sw_latch_ctrl_i;
               lvl_wr_ff <= output_level_value_i;
            end
         end
      end

      // pulse counter keeps the strobe closed for a fixed time
      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            pcnt_ff <= '0;
         end else if (exposure_begin_event_i) begin
            pcnt_ff <= STROBE_CYC - 8'h01;
         end else if (pcnt_ff != '0) begin
            pcnt_ff <= pcnt_ff - 8'h01;
         end
      end

      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            closed_ff <= 1'b0;
            sourced_ff <= 1'b0;
         end else begin
            sourced_ff <= (src_ff != PC_SRC_OFF);
            unique case (pc_out_src_t'(src_ff))
               PC_SRC_OFF: closed_ff <= 1'b0;
               PC_SRC_SW: closed_ff <= nxt_applied;
               PC_SRC_EXPO_PULSE: closed_ff <= exposure_begin_event_i || (pcnt_ff != '0);
               PC_SRC_EXPO_WIN: closed_ff <= exposure_window_level_i;
            endcase
         end
      end

      assign line_closed_o[g] = closed_ff;
      assign line_sourced_o[g] = sourced_ff;
   end

   // ******************************************
   // assertions
   // ******************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_reset_state;
      @(posedge clk_i) disable iff (1'b0)
      sys_rst_i |=> idx_ff == FIRST_PRESET && cnt_ff == CNT_ZERO && !pend_ff && line_closed_o == '0;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

   property p_disabled;
      !preset_cycle_enable_i |=> idx_ff == FIRST_PRESET && cnt_ff == CNT_ZERO;
   endproperty
   a_disabled: assert property (p_disabled) else $error("sequencer moved while disabled");

   property p_count;
      preset_cycle_enable_i && adv_ev && !rew_now && !pend_ff && !roll
      |=> cnt_ff == $past(cnt_ff) + 16'h0001 && $stable(idx_ff);
   endproperty
   a_count: assert property (p_count) else $error("advance count wrong");

   property p_wrap;
      preset_cycle_enable_i && adv_ev && !rew_now && !pend_ff && roll && idx_ff >= preset_total_i
      |=> idx_ff == FIRST_PRESET ##1 active_preset_o == FIRST_PRESET;
   endproperty
   a_wrap: assert property (p_wrap) else $error("index did not wrap");

   property p_step;
      preset_cycle_enable_i && adv_ev && !rew_now && !pend_ff && roll && idx_ff < preset_total_i
      |=> idx_ff == $past(idx_ff) + 5'h01 && cnt_ff == CNT_ZERO;
   endproperty
   a_step: assert property (p_step) else $error("index did not step");

   property p_rew_now;
      preset_cycle_enable_i && rew_ev && !sync_src |=> idx_ff == FIRST_PRESET && !pend_ff;
   endproperty
   a_rew_now: assert property (p_rew_now) else $error("async rewind not immediate");

   property p_rew_defer;
      preset_cycle_enable_i && rew_ev && sync_src && !adv_ev |=> pend_ff && $stable(idx_ff);
   endproperty
   a_rew_defer: assert property (p_rew_defer) else $error("sync rewind not deferred");

   property p_pend_apply;
      preset_cycle_enable_i && pend_ff && adv_ev && !rew_now |=> idx_ff == FIRST_PRESET;
   endproperty
   a_pend_apply: assert property (p_pend_apply) else $error("pending rewind not applied");

   property p_refuse_active;
      preset_wr_i && preset_cycle_enable_i && preset_edit_index_i == idx_ff |-> !pif.wr_en ##1 preset_wr_refused_o;
   endproperty
   a_refuse_active: assert property (p_refuse_active) else $error("active preset written");

   property p_line_off;
      g_line[0].src_ff == PC_SRC_OFF |=> !line_closed_o[0] && !line_sourced_o[0];
   endproperty
   a_line_off: assert property (p_line_off) else $error("off line not open");

   property p_window;
      g_line[1].src_ff == PC_SRC_EXPO_WIN && $stable(g_line[1].src_ff)
      |=> line_closed_o[1] == $past(exposure_window_level_i);
   endproperty
   a_window: assert property (p_window) else $error("window line mismatch");

   property p_pulse;
      g_line[0].src_ff == PC_SRC_EXPO_PULSE && exposure_begin_event_i && !line_cfg_we_i
      |=> line_closed_o[0] [*2];
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe pulse missing");

   property p_latch_hold;
      g_line[0].src_ff == PC_SRC_SW && g_line[0].latch_ff && !sw_latch_apply_i && !line_cfg_we_i
      |=> line_closed_o[0] == $past(g_line[0].applied_ff);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched line changed");

   c_wrap: cover property (preset_cycle_enable_i && adv_ev && roll && idx_ff >= preset_total_i);
   c_defer: cover property (pend_ff && adv_ev);
   c_refused: cover property (preset_wr_refused_o);
   c_pulse: cover property (g_line[0].src_ff == PC_SRC_EXPO_PULSE && exposure_begin_event_i);

endmodule : pc_cycler

/* pc_cycler_tb.sv */
// self-checking testbench for the preset cycler and its output lines
`timescale 1ns/1ps
module pc_cycler_tb;
   import pc_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic pick = 0, cfg_we = 0, latch = 0, lvl = 0, apply = 0, expo_b = 0, expo_w = 0, en = 0;
   logic [1:0] src = 0, ach = 0, rch = 0;
   logic [4:0] total = 5'h01, eidx = 0;
   logic [15:0] div = 0, pdiv = 0, px = 0, py = 0, bx = 16'h0123, by = 16'h0456;
   logic [5:0] ev = 0;
   logic fpick = 0, fjoin = 0, fjwe = 0, pwr = 0;
   logic [4:0] act;
   logic [15:0] rx, ry;
   logic [1:0] lock, closed, sourced;
   logic refused;
   int plen [NUM_LINES];
   int prise [NUM_LINES];
   int fail_count = 0, n_tests = 0;
   // reference model state
   int midx = 1, mcnt = 0, mpend = 0, mtot = 1, mdiv = 0, mach = 0, mrch = 0;
   int mx [32], my [32], md [32];
   bit men = 0, jroi = 0, jdiv = 0;

   always #5 clk_i = ~clk_i;

   pc_cycler i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .output_line_picker_i(pick), .line_cfg_we_i(cfg_we),
      .output_source_choice_i(src), .sw_latch_ctrl_i(latch), .output_level_value_i(lvl),
      .sw_latch_apply_i(apply), .exposure_begin_event_i(expo_b), .exposure_window_level_i(expo_w),
      .preset_cycle_enable_i(en), .preset_total_i(total), .advance_event_choice_i(ach),
      .advance_divider_i(div), .rewind_event_choice_i(rch), .frame_begin_event_i(ev[0]),
      .accepted_trigger_event_i(ev[1]), .counter_done_event_i(ev[2]), .sw_advance_i(ev[3]),
      .acquisition_end_event_i(ev[4]), .sw_rewind_i(ev[5]), .feature_pick_i(fpick), .feature_join_i(fjoin),
      .feature_join_we_i(fjwe), .preset_edit_index_i(eidx), .preset_wr_i(pwr), .per_preset_divider_i(pdiv),
      .roi_x_origin_i(px), .roi_y_origin_i(py), .base_roi_x_i(bx), .base_roi_y_i(by), .active_preset_o(act),
      .roi_x_o(rx), .roi_y_o(ry), .base_locked_o(lock), .preset_wr_refused_o(refused),
      .line_closed_o(closed), .line_sourced_o(sourced));

   pc_line_watch i_watch (.clk_i(clk_i), .line_closed_i(closed), .line_sourced_i(sourced),
      .pulse_len_o(plen), .rise_cnt_o(prise));

   // ******************************
   // shared tasks
   // ******************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   task automatic cfg_line(input logic p, input logic [1:0] s, input logic l, input logic v);
      @(posedge clk_i);
      {pick, src, latch, lvl, cfg_we} <= {p, s, l, v, 1'b1};
      @(posedge clk_i);
      cfg_we <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : cfg_line

   task automatic cfg_seq(input bit e, input int a, input int r, input int d, input int t);
      @(posedge clk_i);
      {en, ach, rch, div, total} <= {e, 2'(a), 2'(r), 16'(d), 5'(t)};
      {men, mach, mrch, mdiv, mtot} = {e, a, r, d, t};
      if (!e) {midx, mcnt, mpend} = {32'd1, 32'd0, 32'd0};
      repeat (3) @(posedge clk_i);
   endtask : cfg_seq

   task automatic join_feat(input logic f, input logic v);
      @(posedge clk_i);
      {fpick, fjoin, fjwe} <= {f, v, 1'b1};
      @(posedge clk_i);
      fjwe <= 1'b0;
      if (f == FEAT_ROI) jroi = v;
      else jdiv = v;
   endtask : join_feat

   task automatic wr_preset(input int i, input int d, input int x, input int y);
      bit ok;
      @(posedge clk_i);
      {eidx, pdiv, px, py, pwr} <= {5'(i), 16'(d), 16'(x), 16'(y), 1'b1};
      @(posedge clk_i);
      pwr <= 1'b0;
      ok = !(men && i == midx);
      // the refusal pulse stands only for the cycle after the write edge
      #1;
      check(refused, !ok);
      repeat (3) @(posedge clk_i);
      if (ok) {md[i], mx[i], my[i]} = {d, x, y};
   endtask : wr_preset

   // pulses one event line, steps the model, then compares the preset index, ROI and lock outputs
   task automatic ev_pulse(input int k);
      int d;
      bit adv;
      bit rew;
      @(posedge clk_i);
      ev[k] <= 1'b1;
      @(posedge clk_i);
      ev <= '0;
      adv = (k == mach);
      rew = (k == 4 && mrch[0]) || (k == 5 && mrch[1]);
      d = jdiv ? md[midx] : mdiv;
      if (d == 0) d = 1;
      if (men && rew && mach >= 2) begin
         midx = 1;
         mcnt = 0;
      end else if (men && adv && mpend != 0) begin
         midx = 1;
         mcnt = 0;
         mpend = 0;
      end else if (men && adv) begin
         mcnt++;
         if (mcnt >= d) begin
            mcnt = 0;
            midx = (midx >= mtot) ? 1 : midx + 1;
         end
      end else if (men && rew) begin
         mpend = 1;
      end
      repeat (4) @(posedge clk_i);
      #1;
      check(act, midx);
      check(rx, (jroi && men) ? mx[midx] : bx);
      check(ry, (jroi && men) ? my[midx] : by);
      check(lock, {jdiv && men, jroi && men});
   endtask : ev_pulse

   initial begin
      #900000;
      fail_count++;
      close_out();
   end

   // ******************************
   // main sequence
   // ******************************
   initial begin
      void'($urandom(96));
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check({act, lock, closed, sourced}, {5'h01, 6'h00});
      for (int i = 1; i < 32; i++) wr_preset(i, $urandom_range(1, 3), $urandom_range(0, 65535), $urandom_range(0, 65535));
      cfg_line(1'b1, PC_SRC_SW, 1'b0, 1'b1);
      check({closed, sourced}, 4'hA);
      cfg_line(1'b0, PC_SRC_SW, 1'b1, 1'b1);
      check({closed, sourced}, 4'hB);
      @(posedge clk_i);
      apply <= 1'b1;
      @(posedge clk_i);
      apply <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      check(closed, 2'h3);
      cfg_line(1'b1, PC_SRC_OFF, 1'b0, 1'b1);
      check({closed[1], sourced[1]}, 2'h0);
      cfg_line(1'b0, PC_SRC_EXPO_PULSE, 1'b0, 1'b0);
      cfg_line(1'b1, PC_SRC_EXPO_WIN, 1'b0, 1'b0);
      for (int n = 0; n < 2; n++) begin
         @(posedge clk_i);
         expo_b <= 1'b1;
         @(posedge clk_i);
         expo_b <= 1'b0;
         repeat (n == 0 ? 48 : STROBE_CYC_INT + 10) @(posedge clk_i);
      end
      check(plen[0], 50 + STROBE_CYC_INT);
      @(posedge clk_i);
      expo_w <= 1'b1;
      repeat (7) @(posedge clk_i);
      expo_w <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(plen[1], 7);
      check(prise[0], 2);
      check(prise[1], 2);
      join_feat(FEAT_ROI, 1'b1);
      for (int k = 0; k < 3; k++) ev_pulse(0);
      cfg_seq(1, PC_ADV_FRAME, PC_REW_NONE, 1, 31);
      for (int k = 0; k < 32; k++) ev_pulse(0);
      cfg_seq(0, PC_ADV_TRIG, PC_REW_ACQ_END, 2, 4);
      cfg_seq(1, PC_ADV_TRIG, PC_REW_ACQ_END, 2, 4);
      foreach (ev[k]) ev_pulse(k == 3 ? 4 : 1);
      cfg_seq(0, PC_ADV_NONE, PC_REW_SW, 1, 3);
      cfg_seq(1, PC_ADV_NONE, PC_REW_SW, 1, 3);
      ev_pulse(3);
      wr_preset(2, 1, 16'hBEEF, 16'h0F0F);
      wr_preset(3, 1, 16'h1234, 16'h4321);
      ev_pulse(3);
      ev_pulse(5);
      join_feat(FEAT_ROI, 1'b0);
      ev_pulse(3);
      // random blocks: every advance choice, random rewind choice and divider 0 to 3
      for (int b = 0; b < 8; b++) begin
         cfg_seq(0, b % 4, $urandom_range(0, 3), $urandom_range(0, 3), $urandom_range(1, 5));
         join_feat(FEAT_DIV, b[1]);
         join_feat(FEAT_ROI, b[2]);
         cfg_seq(1, mach, mrch, mdiv, mtot);
         repeat (12) ev_pulse($urandom_range(0, 5));
      end
      close_out();
   end
endmodule : pc_cycler_tb

/* pc_line_watch.sv */
// external load model that watches the two output lines
`timescale 1ns/1ps
module pc_line_watch
   import pc_pkg::*;
(
   input wire logic clk_i,
   input wire logic [NUM_LINES-1:0] line_closed_i,
   input wire logic [NUM_LINES-1:0] line_sourced_i,
   output int pulse_len_o [NUM_LINES],
   output int rise_cnt_o [NUM_LINES]
);
   int run_ff [NUM_LINES];

   // an unsourced line is an open circuit, so the load sees no current
   always @(posedge clk_i) begin
      for (int l = 0; l < NUM_LINES; l++) begin
         if (line_sourced_i[l] === 1'b1 && line_closed_i[l] === 1'b1) begin
            if (run_ff[l] == 0) rise_cnt_o[l] <= rise_cnt_o[l] + 1;
            run_ff[l] <= run_ff[l] + 1;
         end else begin
            if (run_ff[l] != 0) pulse_len_o[l] <= run_ff[l];
            run_ff[l] <= 0;
         end
      end
   end
endmodule : pc_line_watch

/* pc_pkg.sv */
// package of constants and types for the preset cycler and output lines
package pc_pkg;

   // ******************************************
   // widths and counts
   // ******************************************
   localparam int IDX_W = 5;
   localparam int POS_W = 16;
   localparam int DIV_W = 16;
   localparam int NUM_LINES = 2;
   localparam int NUM_FEAT = 2;
   localparam logic [IDX_W-1:0] FIRST_PRESET = 5'h01;
   localparam logic [DIV_W-1:0] CNT_ZERO = 16'h0000;

   // ******************************************
   // feature picks that may join cycling, and output line picks
   // ******************************************
   localparam logic FEAT_ROI = 1'h0;
   localparam logic FEAT_DIV = 1'h1;
   localparam logic LINE_PICK_A = 1'h0;
   localparam logic LINE_PICK_B = 1'h1;

   // ******************************************
   // strobe pulse timing
   // ******************************************
   localparam int CLK_NS = 10;
   localparam int STROBE_NS = 1000;
   localparam int STROBE_CYC_INT = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PCNT_W = 8;
   localparam logic [PCNT_W-1:0] STROBE_CYC = PCNT_W'(STROBE_CYC_INT);

   // ******************************************
   // selections
   // ******************************************
   typedef enum logic [1:0] {
      PC_SRC_OFF,
      PC_SRC_SW,
      PC_SRC_EXPO_PULSE,
      PC_SRC_EXPO_WIN
   } pc_out_src_t;

   typedef enum logic [1:0] {
      PC_ADV_FRAME,
      PC_ADV_TRIG,
      PC_ADV_COUNTER,
      PC_ADV_NONE
   } pc_adv_src_t;

   typedef enum logic [1:0] {
      PC_REW_NONE,
      PC_REW_ACQ_END,
      PC_REW_SW,
      PC_REW_BOTH
   } pc_rew_src_t;

   // one stored preset entry
   typedef struct packed {
      logic [DIV_W-1:0] divider;
      logic [POS_W-1:0] x_origin;
      logic [POS_W-1:0] y_origin;
   } pc_entry_t;

endpackage : pc_pkg

/* pc_preset_if.sv */
// interface between the sequencer and its preset store
`timescale 1ns/1ps
interface pc_preset_if
   import pc_pkg::*;
();
   logic wr_en;
   logic [IDX_W-1:0] wr_addr;
   pc_entry_t wr_data;
   logic [IDX_W-1:0] rd_addr;
   pc_entry_t rd_data;

   modport seq (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : pc_preset_if

/* pc_preset_mem.sv */
// small preset store with registered read data
`timescale 1ns/1ps
module pc_preset_mem
   import pc_pkg::*;
#(
   parameter int DEPTH = 2 ** IDX_W
) (
   input wire logic clk_i,
   pc_preset_if.mem bus
);

   pc_entry_t mem_ff [DEPTH];
   pc_entry_t rd_ff;

   always_ff @(posedge clk_i) begin
      if (bus.wr_en) begin
         mem_ff[bus.wr_addr] <= bus.wr_data;
      end
   end

   // no reset on the array; entries are defined by software before use
   always_ff @(posedge clk_i) begin
      rd_ff <= mem_ff[bus.rd_addr];
   end

   assign bus.rd_data = rd_ff;

endmodule : pc_preset_mem
